/* design/program_counter_sequencer.sv */
// Four-phase fetch/execute sequencer with program counter and AXI4-Lite registers
// Behaviour
// [RQ1] Each instruction cycle is exactly four system clock periods of phases.
// [RQ2] A word fetched in one cycle is executed in the next while fetching.
// [RQ3] Counter-changing instructions take two cycles; the prefetched word becomes a dummy.
// [RQ4] The counter is 11 bits wide, addressing 2048 words.
// [RQ5] After each fetch the counter advances by one.
// [RQ6] A true skip discards the prefetched word; counter ends at plus two.
// [RQ7] Reset loads zero; each interrupt loads its fixed vector.
// [RQ8] Writing the low byte replaces bits 7..0, keeping bits 10..8.
// [RQ9] Jump or call loads all eleven bits from the instruction field.
// [RQ10] Return restores all eleven bits from the top stack entry.
// [RQ11] Software reads and writes the counter low byte at register 06H.
// [RQ12] Program memory is 2048x14, addressed by counter or table pointer.
// [RQ13] An interrupt is taken only if requested, enabled and stack not full.
// [RQ14] Calls and interrupt acknowledges push the counter on a six-level stack.
// [RQ15] Among pending enabled interrupts the lowest vector is served first.
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module program_counter_sequencer
	import pc_seq_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [pc_seq_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pc_seq_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [pc_seq_pkg::PC_W-1:0] pmem_addr_o,
	input wire logic [pc_seq_pkg::WORD_W-1:0] pmem_data_i,
	input wire logic [7:0] table_pointer_i,
	output logic [3:0] phase_o,
	output logic [pc_seq_pkg::WORD_W-1:0] exec_word_o,
	output logic exec_valid_o,
	output logic [pc_seq_pkg::WORD_W-1:0] table_word_o,
	input wire pc_seq_pkg::xfer_op_t xfer_op_i,
	input wire logic [pc_seq_pkg::PC_W-1:0] xfer_addr_i,
	input wire logic [7:0] counter_low_byte_i,
	input wire logic [pc_seq_pkg::IRQ_N-1:0] irq_req_i,
	input wire logic [pc_seq_pkg::IRQ_N-1:0] irq_en_i,
	output logic [pc_seq_pkg::IRQ_N-1:0] irq_ack_o
);
	import pc_seq_pkg::*;

	function automatic logic [PC_W-1:0] merge_low(input logic [PC_W-1:0] pc, input logic [7:0] lo);
		merge_low = {pc[PC_W-1:8], lo};
	endfunction : merge_low

	// =========================================
	// Phase divider
	logic [1:0] phase_ff;
	logic [3:0] phase_oh_ff;
	logic [31:0] ctrl_ff;
	wire logic run = ctrl_ff[CTRL_RUN_BIT];
	wire logic boundary = (phase_ff == LAST_PHASE) && run;
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			phase_ff <= 2'h0;
			phase_oh_ff <= 4'h1;
		end
		else
		begin
			phase_ff <= phase_ff + 2'h1; // RQ1
			phase_oh_ff <= {phase_oh_ff[2:0], phase_oh_ff[3]};
		end
	end
	assign phase_o = phase_oh_ff;

	// =========================================
	// Return stack
	return_stack_if stk ();
	return_stack #(.LEVELS(STACK_LEVELS)) u_stack (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.st(stk.stack)
	);

	// =========================================
	// Sequencing decisions
	logic [PC_W-1:0] pc_ff; // RQ4
	logic [WORD_W-1:0] instr_ff;
	logic valid_ff;
	logic tbl_sel_ff;
	logic [WORD_W-1:0] tbl_word_ff;
	logic [PC_W-1:0] pmem_addr_ff;
	logic [IRQ_N-1:0] ack_ff;
	logic [7:0] sw_low_ff;
	logic sw_pend_ff;
	wire logic exec_op = valid_ff && !tbl_sel_ff;
	wire logic do_skip = exec_op && xfer_op_i == OP_SKIP;
	wire logic do_jump = exec_op && (xfer_op_i == OP_JUMP || xfer_op_i == OP_CALL);
	wire logic do_call = exec_op && xfer_op_i == OP_CALL;
	wire logic do_ret = exec_op && xfer_op_i == OP_RET;
	wire logic do_low = exec_op && xfer_op_i == OP_LOAD_LOW;
	wire logic do_tbl = exec_op && (xfer_op_i == OP_TABLE || xfer_op_i == OP_TABLE_LAST);
	wire logic quiet = !(do_skip || do_jump || do_ret || do_low || do_tbl) && !tbl_sel_ff;
	wire logic [IRQ_N-1:0] irq_live = irq_req_i & irq_en_i;
	// Lowest set bit wins, which is the lowest vector address
	wire logic [IRQ_N-1:0] irq_pick = irq_live & (~irq_live + 5'h01); // RQ15
	wire logic take_irq = quiet && (irq_live != '0) && !stk.full; // RQ13
	wire logic take_sw = quiet && !take_irq && sw_pend_ff;
	logic [PC_W-1:0] irq_vec;
	always_comb
	begin
		irq_vec = RESET_VECTOR;
		for (int i = IRQ_N - 1; i >= 0; i--)
			if (irq_pick[i])
				irq_vec = IRQ_VECTOR[i]; // RQ7
	end
	wire logic [PC_W-1:0] tbl_addr = {(xfer_op_i == OP_TABLE_LAST) ? LAST_PAGE : pc_ff[PC_W-1:8],
		table_pointer_i};
	wire logic [PC_W-1:0] pc_inc = pc_ff + 11'h001;
	wire logic [PC_W-1:0] nxt_pc =
		tbl_sel_ff ? pc_ff :
		do_jump ? xfer_addr_i : // RQ9
		do_ret ? stk.top : // RQ10
		do_low ? merge_low(pc_ff, counter_low_byte_i) : // RQ8
		do_tbl ? pc_ff :
		take_irq ? irq_vec :
		take_sw ? merge_low(pc_ff, sw_low_ff) : // RQ8
		pc_inc; // RQ5 RQ6
	// Any transfer turns the already fetched word into a dummy
	wire logic nxt_valid = !(tbl_sel_ff || do_skip || do_jump || do_ret || do_low || do_tbl
		|| take_irq || take_sw); // RQ3 RQ6

	// Interrupt pushes the address of the discarded word so it is fetched again on return
	assign stk.push = boundary && (do_call || take_irq); // RQ14
	assign stk.push_data = pc_ff;
	assign stk.pop = boundary && do_ret;

	// =========================================
	// Pipeline registers
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			pc_ff <= RESET_VECTOR; // RQ7
			pmem_addr_ff <= RESET_VECTOR;
			instr_ff <= '0;
			valid_ff <= 1'b0;
			tbl_sel_ff <= 1'b0;
			tbl_word_ff <= '0;
			ack_ff <= '0;
		end
		else
		begin
			ack_ff <= (boundary && take_irq) ? irq_pick : '0;
			if (boundary)
			begin
				pc_ff <= nxt_pc;
				pmem_addr_ff <= do_tbl ? tbl_addr : nxt_pc; // RQ12
				instr_ff <= pmem_data_i; // RQ2
				valid_ff <= nxt_valid;
				tbl_sel_ff <= do_tbl;
				if (tbl_sel_ff)
					tbl_word_ff <= pmem_data_i;
			end
		end
	end
	assign pmem_addr_o = pmem_addr_ff;
	assign exec_word_o = instr_ff;
	assign exec_valid_o = valid_ff;
	assign table_word_o = tbl_word_ff;
	assign irq_ack_o = ack_ff;

	// =========================================
	// AXI4-Lite write channel
	logic aw_got_ff;
	logic w_got_ff;
	logic [AXI_AW-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	wire logic aw_hs = s_axi_awvalid && !aw_got_ff && !bvalid_ff;
	wire logic w_hs = s_axi_wvalid && !w_got_ff && !bvalid_ff;
	wire logic wr_go = aw_got_ff && w_got_ff;
	wire logic wr_low = wr_go && awaddr_ff == LOW_BYTE_ADDR && wstrb_ff[0]; // RQ11
	wire logic wr_map = awaddr_ff == LOW_BYTE_ADDR || awaddr_ff == CTRL_ADDR
		|| awaddr_ff == STATUS_ADDR;
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end
		else
		begin
			if (aw_hs)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_hs)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready = !w_got_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// Software short jump waits for the next quiet instruction boundary at which no interrupt is taken
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			ctrl_ff <= CTRL_RESET;
			sw_pend_ff <= 1'b0;
			sw_low_ff <= 8'h00;
		end
		else
		begin
			if (wr_go && awaddr_ff == CTRL_ADDR && wstrb_ff[0])
				ctrl_ff[7:0] <= wdata_ff[7:0];
			if (wr_low)
			begin
				sw_pend_ff <= 1'b1; // RQ11
				sw_low_ff <= wdata_ff[7:0];
			end
			else if (boundary && take_sw)
				sw_pend_ff <= 1'b0;
		end
	end

	// =========================================
	// AXI4-Lite read channel
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	wire logic ar_hs = s_axi_arvalid && !rvalid_ff;
	wire logic [31:0] status_word = {11'h000, valid_ff, 1'b0, stk.depth, 5'h00, pc_ff};
	wire logic rd_map = s_axi_araddr == LOW_BYTE_ADDR || s_axi_araddr == CTRL_ADDR
		|| s_axi_araddr == STATUS_ADDR;
	wire logic [31:0] rd_mux =
		s_axi_araddr == LOW_BYTE_ADDR ? {24'h000000, pc_ff[7:0]} : // RQ11
		s_axi_araddr == CTRL_ADDR ? ctrl_ff :
		s_axi_araddr == STATUS_ADDR ? status_word : 32'h0000_0000;
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end
		else if (ar_hs)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// =========================================
	// Assertions
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_phase_walk;
		phase_ff == 2'h1 ##1 phase_ff == 2'h2 ##1 phase_ff == 2'h3 ##1 phase_ff == 2'h0;
	endsequence
	property p_phase;
		phase_ff == 2'h0 |=> s_phase_walk;
	endproperty
	a_phase: assert property (p_phase) else $error("phase walk broken"); // RQ1
	property p_pipe;
		boundary |=> instr_ff == $past(pmem_data_i);
	endproperty
	a_pipe: assert property (p_pipe) else $error("fetched word not handed to execute"); // RQ2
	property p_dummy;
		// An interrupt or queued short jump at the dummy boundary legally makes another dummy
		boundary && do_jump |=> !valid_ff ##4 (valid_ff || !run || irq_ack_o != '0 || $past(take_sw));
	endproperty
	a_dummy: assert property (p_dummy) else $error("jump did not insert one dummy"); // RQ3
	property p_inc;
		boundary && quiet && !take_irq && !take_sw |=> pc_ff == $past(pc_ff) + 11'h001;
	endproperty
	a_inc: assert property (p_inc) else $error("counter did not advance by one"); // RQ5
	property p_skip;
		boundary && do_skip |=> pc_ff == $past(pc_ff) + 11'h001 && !valid_ff;
	endproperty
	a_skip: assert property (p_skip) else $error("skip handling wrong"); // RQ6
	property p_vec;
		boundary && take_irq && irq_live[0] |=> pc_ff == 11'h004 && irq_ack_o == 5'h01;
	endproperty
	a_vec: assert property (p_vec) else $error("first vector wrong"); // RQ7
	property p_low;
		boundary && do_low |=> pc_ff == {$past(pc_ff[10:8]), $past(counter_low_byte_i)};
	endproperty
	a_low: assert property (p_low) else $error("low byte load wrong"); // RQ8
	property p_jump;
		boundary && do_jump |=> pc_ff == $past(xfer_addr_i);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong"); // RQ9
	property p_ret;
		boundary && do_ret |=> pc_ff == $past(stk.top);
	endproperty
	a_ret: assert property (p_ret) else $error("return address wrong"); // RQ10
	property p_gate;
		irq_ack_o != '0 |-> $past(stk.full) == 1'b0 && ($past(irq_live) & irq_ack_o) != '0;
	endproperty
	a_gate: assert property (p_gate) else $error("interrupt taken while blocked"); // RQ13
	property p_prio;
		irq_ack_o != '0 |-> ((irq_ack_o - 5'h01) & $past(irq_live)) == '0;
	endproperty
	a_prio: assert property (p_prio) else $error("lower vector was pending"); // RQ15
	property p_push;
		boundary && do_call |=> stk.top == $past(pc_ff);
	endproperty
	a_push: assert property (p_push) else $error("call did not push return address"); // RQ14
endmodule : program_counter_sequencer
`default_nettype wire

/* design/pc_seq_pkg.sv */
// Shared constants and types for the program counter sequencer
`default_nettype none
package pc_seq_pkg;
	localparam int PC_W = 11;
	localparam int WORD_W = 14;
	localparam int STACK_LEVELS = 6;
	localparam int PHASES = 4;
	localparam int IRQ_N = 5;
	localparam int AXI_AW = 8;
	localparam logic [1:0] LAST_PHASE = 2'h3;
	// Register indices; byte address is four times the index
	localparam logic [7:0] LOW_BYTE_IDX = 8'h06;
	localparam logic [7:0] STATUS_IDX = 8'h10;
	localparam logic [7:0] CTRL_IDX = 8'h11;
	localparam logic [AXI_AW-1:0] LOW_BYTE_ADDR = 8'h18;
	localparam logic [AXI_AW-1:0] STATUS_ADDR = 8'h40;
	localparam logic [AXI_AW-1:0] CTRL_ADDR = 8'h44;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STATUS_DEPTH_LSB = 16;
	localparam int STATUS_VALID_BIT = 20;
	localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
	localparam logic [2:0] LAST_PAGE = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Vectors in priority order, lowest address first
	localparam logic [PC_W-1:0] IRQ_VECTOR [IRQ_N] = '{11'h004, 11'h008, 11'h00c, 11'h014, 11'h018};
	typedef enum logic [2:0] {
		OP_SEQ = 3'h0,
		OP_SKIP = 3'h1,
		OP_JUMP = 3'h2,
		OP_CALL = 3'h3,
		OP_RET = 3'h4,
		OP_LOAD_LOW = 3'h5,
		OP_TABLE = 3'h6,
		OP_TABLE_LAST = 3'h7
	} xfer_op_t;
endpackage : pc_seq_pkg
`default_nettype wire

/* design/return_stack_if.sv */
// Carrier between the sequencer and its return stack
`default_nettype none
interface return_stack_if;
	import pc_seq_pkg::*;
	logic push;
	logic pop;
	logic [PC_W-1:0] push_data;
	logic [PC_W-1:0] top;
	logic full;
	logic [2:0] depth;
	modport seq (output push, pop, push_data, input top, full, depth);
	modport stack (input push, pop, push_data, output top, full, depth);
endinterface : return_stack_if
`default_nettype wire

/* design/return_stack.sv */
// Return address stack; only its depth is visible to software, in the status register
`default_nettype none
module return_stack
	import pc_seq_pkg::*;
#(
	parameter int LEVELS = STACK_LEVELS
)(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	return_stack_if.stack st
);
	logic [PC_W-1:0] mem_ff [LEVELS];
	logic [2:0] depth_ff;
	assign st.top = mem_ff[0];
	assign st.full = (depth_ff == 3'(LEVELS));
	assign st.depth = depth_ff;
	// =========================================
	// Storage
	// Shifting keeps the newest entry at index 0; a push when full drops the oldest
	always_ff @(posedge core_clk_i)
	begin
		if (st.push)
		begin
			mem_ff[0] <= st.push_data;
			for (int i = 1; i < LEVELS; i++)
				mem_ff[i] <= mem_ff[i-1];
		end
		else if (st.pop)
		begin
			for (int i = 0; i < LEVELS - 1; i++)
				mem_ff[i] <= mem_ff[i+1];
		end
	end
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			depth_ff <= 3'h0;
		else if (st.push && !st.full)
			depth_ff <= depth_ff + 3'h1;
		else if (st.pop && depth_ff != 3'h0)
			depth_ff <= depth_ff - 3'h1;
	end
endmodule : return_stack
`default_nettype wire

/* sim/pmem_model.sv */
// Program memory partner: 2048 words of 14 bits, answering without wait states
`default_nettype none
module pmem_model (
	input wire logic [pc_seq_pkg::PC_W-1:0] addr_i,
	output logic [pc_seq_pkg::WORD_W-1:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import pc_seq_pkg::*;
	// ====
	// Storage
	logic [WORD_W-1:0] mem [2048];
	initial
	begin
		// Word carries its own address so a wrong fetch is visible
		for (int i = 0; i < 2048; i++)
			mem[i] = {i[10:0], 3'h5};
	end
	assign data_o = mem[addr_i];
endmodule : pmem_model
`default_nettype wire

/* sim/program_counter_sequencer_test.sv */
// Self-checking bench for the program counter sequencer
`default_nettype none
module program_counter_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pc_seq_pkg::*;
	// ====
	// Signals
	logic core_clk_i = 1'b0, resetn_i = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_valid_o;
	logic [AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'h1, phase_o;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [PC_W-1:0] pmem_addr_o, xfer_addr_i = 11'h000, ack_pc, p, e;
	logic [WORD_W-1:0] pmem_data_i, exec_word_o, table_word_o;
	logic [7:0] table_pointer_i = 8'h00, counter_low_byte_i = 8'h00;
	logic [IRQ_N-1:0] irq_req_i = 5'h00, irq_en_i = 5'h00, irq_ack_o, ack_seen = 5'h00;
	xfer_op_t xfer_op_i = OP_SEQ;
	int mismatches = 0, compares = 0, cycles = 0, edges;
	logic [PC_W-1:0] vec [5] = '{11'h004, 11'h008, 11'h00c, 11'h014, 11'h018};
	always #2.5 core_clk_i = ~core_clk_i;
	program_counter_sequencer dut (
		.core_clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pmem_addr_o,
		.pmem_data_i, .table_pointer_i, .phase_o, .exec_word_o, .exec_valid_o,
		.table_word_o, .xfer_op_i, .xfer_addr_i, .counter_low_byte_i, .irq_req_i,
		.irq_en_i, .irq_ack_o
	);
	pmem_model mem (.addr_i(pmem_addr_o), .data_o(pmem_data_i));
	// ====
	// Monitor: keeps the first acknowledge, since later ones overwrite the pulse
	always @(posedge core_clk_i)
	begin
		cycles <= cycles + 1;
		if (resetn_i !== 1'b1)
			ack_seen <= 5'h00;
		else if (irq_ack_o !== 5'h00 && ack_seen === 5'h00)
		begin
			ack_seen <= irq_ack_o;
			ack_pc <= pmem_addr_o;
		end
		// Run needs under a thousand cycles; the ceiling leaves wide margin
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			results();
		end
	end
	// ====
	// Shared tasks
	function automatic logic [WORD_W-1:0] w(input logic [PC_W-1:0] a);
		return {a, 3'h5};
	endfunction : w
	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
		compares++;
		if (g !== ex)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, ex, g);
		end
	endtask : chk
	task automatic results;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic rst;
		resetn_i <= 1'b0;
		repeat (5) @(posedge core_clk_i);
		resetn_i <= 1'b1;
	endtask : rst
	// Op is held until the boundary edge; state is read one edge later, settled
	task automatic cyc(input xfer_op_t op, input logic [10:0] a = 11'h0, input logic [7:0] b = 8'h0);
		xfer_op_i <= op;
		xfer_addr_i <= a;
		counter_low_byte_i <= b;
		edges = 0;
		do
		begin
			@(posedge core_clk_i);
			edges++;
		end
		while (phase_o !== 4'b1000);
		xfer_op_i <= OP_SEQ;
		@(posedge core_clk_i);
	endtask : cyc
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk_i);
			if (s_axi_awready === 1'b1 && s_axi_awvalid === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1 && s_axi_wvalid === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// Idle edge so a following call never drives bready twice in one step
		@(posedge core_clk_i);
	endtask : axw
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk_i);
		while (!(s_axi_arready === 1'b1 && s_axi_arvalid === 1'b1));
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk_i);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk_i);
	endtask : axr
	// ====
	// Scenarios
	task automatic t_regs;
		axr(STATUS_ADDR);
		chk("reset pc", 0, d[10:0]);
		axr(CTRL_ADDR);
		chk("ctrl", CTRL_RESET, d);
		axr(8'h80);
		chk("rd resp", RESP_SLVERR, r);
		axw(8'h80, 32'h1);
		chk("wr resp", RESP_SLVERR, r);
		// Clearing run freezes the counter while phases keep turning
		axw(CTRL_ADDR, 32'h0);
		p = pmem_addr_o;
		repeat (8) @(posedge core_clk_i);
		chk("frozen", p, pmem_addr_o);
		axr(CTRL_ADDR);
		chk("ctrl off", 32'h0, d);
		axw(CTRL_ADDR, 32'h1);
		chk("ctrl resp", RESP_OKAY, r);
		$display("regs done");
	endtask : t_regs
	task automatic t_seq;
		cyc(OP_SEQ);
		repeat (3)
		begin
			p = pmem_addr_o;
			cyc(OP_SEQ);
			chk("len", 4, edges + 1);
			chk("phase", 1, phase_o);
			chk("word", w(p), exec_word_o);
			chk("valid", 1, exec_valid_o);
			chk("inc", p + 11'h1, pmem_addr_o);
		end
		$display("seq done");
	endtask : t_seq
	task automatic t_table;
		for (int k = 0; k < 2; k++)
		begin
			p = pmem_addr_o;
			e = {k ? 3'h7 : p[10:8], 8'hc3 ^ k[7:0]};
			table_pointer_i <= e[7:0];
			cyc(k ? OP_TABLE_LAST : OP_TABLE);
			chk("tbl addr", e, pmem_addr_o);
			cyc(OP_SEQ);
			chk("tbl word", w(e), table_word_o);
			cyc(OP_SEQ);
			chk("tbl back", w(p), exec_word_o);
		end
		$display("table done");
	endtask : t_table
	task automatic t_skip;
		p = pmem_addr_o;
		cyc(OP_SKIP);
		chk("skip dummy", 0, exec_valid_o);
		chk("skip addr", p + 11'h1, pmem_addr_o);
		cyc(OP_SEQ);
		chk("skip word", w(p + 11'h1), exec_word_o);
		$display("skip done");
	endtask : t_skip
	task automatic t_jump;
		cyc(OP_JUMP, 11'h7f3);
		chk("jmp addr", 11'h7f3, pmem_addr_o);
		chk("jmp dummy", 0, exec_valid_o);
		cyc(OP_SEQ);
		chk("jmp word", w(11'h7f3), exec_word_o);
		chk("jmp valid", 1, exec_valid_o);
		axr(STATUS_ADDR);
		chk("pc width", 11'h7f4, d[10:0]);
		chk("st valid", 1, d[20]);
		$display("jump done");
	endtask : t_jump
	task automatic t_low;
		cyc(OP_LOAD_LOW, 11'h000, 8'ha7);
		chk("ld addr", 11'h7a7, pmem_addr_o);
		cyc(OP_SEQ);
		chk("ld word", w(11'h7a7), exec_word_o);
		axr(LOW_BYTE_ADDR);
		chk("low rd", 8'ha8, d[7:0]);
		axw(LOW_BYTE_ADDR, 32'h3c);
		chk("low wr resp", RESP_OKAY, r);
		// The queued write lands at the first boundary after it, possibly already passed, so its word executes at one of the next two
		cyc(OP_SEQ);
		if (exec_valid_o === 1'b0)
			cyc(OP_SEQ);
		chk("low wr word", w(11'h73c), exec_word_o);
		$display("low done");
	endtask : t_low
	task automatic t_stack;
		for (int i = 0; i < 6; i++)
		begin
			p = pmem_addr_o;
			cyc(OP_CALL, 11'h100 | i[10:0]);
			cyc(OP_SEQ);
		end
		chk("call word", w(11'h105), exec_word_o);
		axr(STATUS_ADDR);
		chk("depth", 6, d[18:16]);
		irq_req_i <= 5'h01;
		irq_en_i <= 5'h01;
		repeat (2) cyc(OP_SEQ);
		chk("irq held", 0, ack_seen);
		cyc(OP_RET);
		chk("ret addr", p, pmem_addr_o);
		repeat (3) cyc(OP_SEQ);
		chk("irq ack", 5'h01, ack_seen);
		irq_req_i <= 5'h00;
		$display("stack done");
	endtask : t_stack
	task automatic t_irq;
		for (int i = 0; i < 5; i++)
		begin
			rst();
			irq_req_i <= 5'h1f;
			irq_en_i <= 5'h1f << i;
			repeat (3) cyc(OP_SEQ);
			chk("irq prio", 5'h01 << i, ack_seen);
			chk("irq vec", vec[i], ack_pc);
		end
		$display("irq done");
	endtask : t_irq
	// ====
	// Main sequence
	initial
	begin
		@(posedge core_clk_i);
		rst();
		t_regs();
		t_seq();
		t_table();
		t_skip();
		t_jump();
		t_low();
		t_stack();
		t_irq();
		results();
	end
endmodule : program_counter_sequencer_test
`default_nettype wire
